// File: src/hub_release_and_config_byte.sv
// release number and first configuration byte storage with derived hub controls
//
// Summary of operation
// - hold 16-bit BCD release at 04h, 05h
// - load from EEPROM or SMBus writer
// - bit 7: zero bus, one self power
// - self power: all ports available, 500mA
// - dynamic switching overrides select with sense pin
// - bit 5 forces full-speed-only attachment
// - bit 4 picks shared or per-port translators
// - host single-TT choice overrides per-port translators
// - bit 3 suppresses EOP at EOF1
// - EOP at EOF1 only full speed, idle
// - dynamic flag: one enables sense-pin switching
`timescale 1ns/1ps
module hub_release_and_config_byte #(
  parameter int PORTS = hub_cfg_pkg::DEFAULT_PORTS
) (
  input wire logic clock,
  input wire logic rst,
  input wire logic eeprom_source,
  input wire logic eeprom_wr_en,
  input wire logic [7:0] eeprom_addr,
  input wire logic [7:0] eeprom_wr_data,
  input wire logic smbus_wr_en,
  input wire logic smbus_rd_en,
  input wire logic [7:0] smbus_addr,
  input wire logic [7:0] smbus_wr_data,
  output logic [7:0] smbus_rd_data,
  output logic smbus_rd_valid,
  input wire logic local_supply_present,
  input wire logic host_single_tt,
  input wire logic [PORTS-1:0] bus_port_allowed,
  input wire logic full_speed_mode,
  input wire logic eof1_point,
  input wire logic downstream_traffic_seen,
  output logic [15:0] release_number,
  output logic self_powered,
  output logic [PORTS-1:0] port_available,
  output logic [PORTS-1:0] port_high_current,
  output logic high_speed_off,
  output logic per_port_translator_active,
  output logic dynamic_power_enable,
  output logic eop_at_eof1
);
  // stored bytes
  logic [7:0] release_number_low;
  logic [7:0] release_number_high;
  logic [7:0] cfg_one;
  logic dyn_flag;

  // write path
  logic eeprom_taken;
  logic smbus_taken;
  logic [7:0] wr_data;
  logic eeprom_at_low;
  logic eeprom_at_high;
  logic eeprom_at_one;
  logic eeprom_at_two;
  logic smbus_at_low;
  logic smbus_at_high;
  logic smbus_at_one;
  logic smbus_at_two;
  logic hit_low;
  logic hit_high;
  logic hit_cfg_one;
  logic hit_cfg_two;
  logic [7:0] cfg_one_in;
  logic dyn_in;
  logic [7:0] next_release_number_low;
  logic [7:0] next_release_number_high;
  wire [7:0] next_cfg_one;
  logic next_dyn_flag;

  // read path
  logic [7:0] view_cfg_one;
  logic [7:0] view_cfg_two;
  logic [7:0] rd_term_low;
  logic [7:0] rd_term_high;
  logic [7:0] rd_term_one;
  logic [7:0] rd_term_two;
  logic [7:0] next_rd_data;
  logic [7:0] next_smbus_rd_data;
  logic next_smbus_rd_valid;

  // derived controls
  logic sel_supply;
  logic sel_hs_off;
  logic sel_per_port;
  logic sel_eop_off;
  wire [PORTS-1:0] next_port_available;
  wire [PORTS-1:0] next_port_high_current;
  logic next_per_port_translator_active;
  logic next_high_speed_off;
  logic next_dynamic_power_enable;
  logic [15:0] next_release_number;
  logic fs_frame_end;
  logic frame_quiet;
  logic eop_allowed;
  logic next_eop_at_eof1;

  // one writer at a time; the source strap chooses which is honoured
  assign eeprom_taken = eeprom_source && eeprom_wr_en;
  assign smbus_taken = !eeprom_source && smbus_wr_en;
  assign wr_data = eeprom_source ? eeprom_wr_data : smbus_wr_data;

  // each source decodes its own address, so no address mux sits in front
  assign eeprom_at_low = eeprom_addr == hub_cfg_pkg::REL_LOW_ADDR;
  assign eeprom_at_high = eeprom_addr == hub_cfg_pkg::REL_HIGH_ADDR;
  assign eeprom_at_one = eeprom_addr == hub_cfg_pkg::CFG_ONE_ADDR;
  assign eeprom_at_two = eeprom_addr == hub_cfg_pkg::CFG_TWO_ADDR;
  assign smbus_at_low = smbus_addr == hub_cfg_pkg::REL_LOW_ADDR;
  assign smbus_at_high = smbus_addr == hub_cfg_pkg::REL_HIGH_ADDR;
  assign smbus_at_one = smbus_addr == hub_cfg_pkg::CFG_ONE_ADDR;
  assign smbus_at_two = smbus_addr == hub_cfg_pkg::CFG_TWO_ADDR;

  assign hit_low = (eeprom_taken && eeprom_at_low) || (smbus_taken && smbus_at_low);
  assign hit_high = (eeprom_taken && eeprom_at_high) || (smbus_taken && smbus_at_high);
  assign hit_cfg_one = (eeprom_taken && eeprom_at_one) || (smbus_taken && smbus_at_one);
  assign hit_cfg_two = (eeprom_taken && eeprom_at_two) || (smbus_taken && smbus_at_two);

  // reserved bit is masked on the way in so it can never be stored
  assign cfg_one_in = wr_data & hub_cfg_pkg::CFG_ONE_WRITABLE;
  // only the dynamic power flag of the second byte is kept here
  assign dyn_in = wr_data[hub_cfg_pkg::DYN_POWER_BIT];

  // the two release bytes are not paired: each lands on its own write
  assign next_release_number_low = hit_low ? wr_data : release_number_low;
  assign next_release_number_high = hit_high ? wr_data : release_number_high;
  assign next_dyn_flag = hit_cfg_two ? dyn_in : dyn_flag;

  genvar b;
  generate
    for (b = 0; b < $bits(cfg_one); b++) begin : g_cfg_bit
      assign next_cfg_one[b] = hit_cfg_one ? cfg_one_in[b] : cfg_one[b];
    end
  endgenerate

  // stored bytes reset to zero, as an unloaded part would read
  always_ff @(posedge clock) begin
    if (rst) begin
      release_number_low <= hub_cfg_pkg::REL_LOW_RESET;
    end else begin
      release_number_low <= next_release_number_low;
    end
  end

  always_ff @(posedge clock) begin
    if (rst) begin
      release_number_high <= hub_cfg_pkg::REL_HIGH_RESET;
    end else begin
      release_number_high <= next_release_number_high;
    end
  end

  always_ff @(posedge clock) begin
    if (rst) begin
      cfg_one <= hub_cfg_pkg::CFG_ONE_RESET;
    end else begin
      cfg_one <= next_cfg_one;
    end
  end

  always_ff @(posedge clock) begin
    if (rst) begin
      dyn_flag <= hub_cfg_pkg::CFG_TWO_DYN_RESET;
    end else begin
      dyn_flag <= next_dyn_flag;
    end
  end

  // reads ignore the strap; the reserved bit is forced low again on the way out
  assign view_cfg_one = cfg_one & hub_cfg_pkg::CFG_ONE_WRITABLE;
  assign view_cfg_two = {dyn_flag, 7'h00};

  // an unmapped address selects no term and reads zero
  assign rd_term_low = smbus_at_low ? release_number_low : 8'h00;
  assign rd_term_high = smbus_at_high ? release_number_high : 8'h00;
  assign rd_term_one = smbus_at_one ? view_cfg_one : 8'h00;
  assign rd_term_two = smbus_at_two ? view_cfg_two : 8'h00;
  assign next_rd_data = rd_term_low | rd_term_high | rd_term_one | rd_term_two;

  // data holds until the next read so a slow reader still finds it
  assign next_smbus_rd_data = smbus_rd_en ? next_rd_data : smbus_rd_data;
  assign next_smbus_rd_valid = smbus_rd_en;

  always_ff @(posedge clock) begin
    if (rst) begin
      smbus_rd_valid <= 1'b0;
    end else begin
      smbus_rd_valid <= next_smbus_rd_valid;
    end
  end

  always_ff @(posedge clock) begin
    if (rst) begin
      smbus_rd_data <= 8'h00;
    end else begin
      smbus_rd_data <= next_smbus_rd_data;
    end
  end

  assign sel_supply = cfg_one[hub_cfg_pkg::SUPPLY_BIT];
  assign sel_hs_off = cfg_one[hub_cfg_pkg::HS_OFF_BIT];
  assign sel_per_port = cfg_one[hub_cfg_pkg::PER_PORT_TT_BIT];
  assign sel_eop_off = cfg_one[hub_cfg_pkg::EOP_SUPPRESS_BIT];

  // the sense pin is synchronised inside before it may override the select bit
  supply_source_resolver supply_resolve (
    .clock(clock),
    .rst(rst),
    .local_supply_present(local_supply_present),
    .dynamic_power_enable(dyn_flag),
    .supply_source_select(sel_supply),
    .self_powered(self_powered)
  );

  // a bus-powered hub cannot promise every port, so the per-port allowance decides there
  genvar p;
  generate
    for (p = 0; p < PORTS; p++) begin : g_port
      assign next_port_available[p] = self_powered | bus_port_allowed[p];
      assign next_port_high_current[p] = self_powered;
    end
  endgenerate

  always_ff @(posedge clock) begin
    if (rst) begin
      port_available <= '0;
    end else begin
      port_available <= next_port_available;
    end
  end

  always_ff @(posedge clock) begin
    if (rst) begin
      port_high_current <= '0;
    end else begin
      port_high_current <= next_port_high_current;
    end
  end

  // the host may force single-translator operation at any time
  assign next_per_port_translator_active = sel_per_port && !host_single_tt;

  always_ff @(posedge clock) begin
    if (rst) begin
      per_port_translator_active <= 1'b0;
    end else begin
      per_port_translator_active <= next_per_port_translator_active;
    end
  end

  // field controls sit one register past the stored byte
  assign next_high_speed_off = sel_hs_off;

  always_ff @(posedge clock) begin
    if (rst) begin
      high_speed_off <= 1'b0;
    end else begin
      high_speed_off <= next_high_speed_off;
    end
  end

  // reported so the power logic outside knows the switching mode
  assign next_dynamic_power_enable = dyn_flag;

  always_ff @(posedge clock) begin
    if (rst) begin
      dynamic_power_enable <= 1'b0;
    end else begin
      dynamic_power_enable <= next_dynamic_power_enable;
    end
  end

  // bcd is kept as written; no digit check is made
  assign next_release_number = {release_number_high, release_number_low};

  always_ff @(posedge clock) begin
    if (rst) begin
      release_number <= 16'h0000;
    end else begin
      release_number <= next_release_number;
    end
  end

  // a full-speed hub only window; EOF1 must be quiet for the packet to be sent
  assign fs_frame_end = eof1_point && full_speed_mode;
  assign frame_quiet = !downstream_traffic_seen;
  // the suppress bit overrides every other condition
  assign eop_allowed = !sel_eop_off;
  assign next_eop_at_eof1 = fs_frame_end && frame_quiet && eop_allowed;

  always_ff @(posedge clock) begin
    if (rst) begin
      eop_at_eof1 <= 1'b0;
    end else begin
      eop_at_eof1 <= next_eop_at_eof1;
    end
  end
endmodule

// File: src/hub_cfg_pkg.sv
// constants for the hub release number and first configuration byte
package hub_cfg_pkg;
  localparam logic [7:0] REL_LOW_ADDR = 8'h04;
  localparam logic [7:0] REL_HIGH_ADDR = 8'h05;
  localparam logic [7:0] CFG_ONE_ADDR = 8'h06;
  localparam logic [7:0] CFG_TWO_ADDR = 8'h07;
  localparam logic [7:0] REL_LOW_RESET = 8'h00;
  localparam logic [7:0] REL_HIGH_RESET = 8'h00;
  localparam logic [7:0] CFG_ONE_RESET = 8'h00;
  localparam logic CFG_TWO_DYN_RESET = 1'b0;
  localparam int SUPPLY_BIT = 7;
  localparam int RESERVED_BIT = 6;
  localparam int HS_OFF_BIT = 5;
  localparam int PER_PORT_TT_BIT = 4;
  localparam int EOP_SUPPRESS_BIT = 3;
  localparam int DYN_POWER_BIT = 7;
  localparam logic [7:0] CFG_ONE_WRITABLE = 8'hBF;
  localparam int DEFAULT_PORTS = 7;
  localparam int SYNC_STAGES = 2;
endpackage

// File: src/supply_source_resolver.sv
// synchronises the local supply sense pin and resolves self or bus power
`timescale 1ns/1ps
module supply_source_resolver (
  input wire logic clock,
  input wire logic rst,
  input wire logic local_supply_present,
  input wire logic dynamic_power_enable,
  input wire logic supply_source_select,
  output logic self_powered
);
  logic [hub_cfg_pkg::SYNC_STAGES-1:0] sense_sync;
  logic sense_clean;
  logic next_self_powered;

  // the pin is asynchronous; only the second stage is read
  always_ff @(posedge clock) begin
    if (rst) begin
      sense_sync <= '0;
    end else begin
      sense_sync <= {sense_sync[hub_cfg_pkg::SYNC_STAGES-2:0], local_supply_present};
    end
  end

  assign sense_clean = sense_sync[hub_cfg_pkg::SYNC_STAGES-1];
  // the select bit is ignored once dynamic switching is on
  assign next_self_powered = dynamic_power_enable ? sense_clean : supply_source_select;

  always_ff @(posedge clock) begin
    if (rst) begin
      self_powered <= 1'b0;
    end else begin
      self_powered <= next_self_powered;
    end
  end
endmodule

// File: testbench/hub_cfg_monitor.sv
// checker for read strobes, supply, translator and frame-end outputs
`timescale 1ns/1ps
module hub_cfg_monitor #(parameter int PORTS = 7) (
  input wire logic clock,
  input wire logic rst,
  input wire logic smbus_rd_en,
  input wire logic [7:0] smbus_addr,
  input wire logic [7:0] smbus_rd_data,
  input wire logic smbus_rd_valid,
  input wire logic eof1_point,
  input wire logic full_speed_mode,
  input wire logic downstream_traffic_seen,
  input wire logic eop_at_eof1,
  input wire logic self_powered,
  input wire logic [PORTS-1:0] port_available,
  input wire logic [PORTS-1:0] port_high_current,
  input wire logic host_single_tt,
  input wire logic per_port_translator_active
);
  default clocking @(posedge clock); endclocking
  default disable iff (rst);
  a_read_valid_pulse: assert property (smbus_rd_en |=> smbus_rd_valid)
    else $error("read strobe gave no valid");
  a_no_stray_valid: assert property (!smbus_rd_en |=> !smbus_rd_valid)
    else $error("valid without read");
  a_reserved_reads_zero: assert property (smbus_rd_valid && $past(smbus_addr) ==
    hub_cfg_pkg::CFG_ONE_ADDR |-> !smbus_rd_data[6]) else $error("reserved bit set");
  a_eop_needs_idle_fs: assert property (eop_at_eof1 |->
    $past(eof1_point && full_speed_mode && !downstream_traffic_seen)) else $error("eop cause");
  a_eop_single_cycle: assert property (eop_at_eof1 |=> !eop_at_eof1)
    else $error("eop too long");
  a_single_tt_wins: assert property (host_single_tt |=> !per_port_translator_active)
    else $error("translator override lost");
  a_self_all_ports: assert property ($past(self_powered) |-> &port_available
    && &port_high_current) else $error("self power ports wrong");
  a_bus_no_high: assert property (!$past(self_powered) |-> port_high_current == '0)
    else $error("bus power high current");
endmodule
bind hub_release_and_config_byte hub_cfg_monitor #(.PORTS(PORTS)) u_mon (.*);

// File: testbench/cfg_source_model.sv
// stand-in for the eeprom loader and smbus host on the register port
`timescale 1ns/1ps
module cfg_source_model (
  input wire logic clock,
  output logic eeprom_source,
  output logic eeprom_wr_en,
  output logic smbus_wr_en,
  output logic smbus_rd_en,
  output logic [7:0] smbus_addr,
  output logic [7:0] smbus_wr_data
);
  initial {eeprom_source, eeprom_wr_en, smbus_wr_en, smbus_rd_en, smbus_addr, smbus_wr_data} = '0;
  task automatic access(input logic ue, sel, rd, input logic [7:0] a, d);
    repeat ($urandom_range(2)) @(negedge clock);
    @(negedge clock);
    eeprom_source = sel;
    {eeprom_wr_en, smbus_wr_en, smbus_rd_en} = {ue & !rd, !ue & !rd, rd};
    smbus_addr = a;
    smbus_wr_data = d;
    @(negedge clock);
    {eeprom_wr_en, smbus_wr_en, smbus_rd_en} = '0;
    // released lines show the inverse so stale values cannot pass
    smbus_addr = ~a;
    smbus_wr_data = ~d;
  endtask
endmodule

// File: testbench/hub_release_and_config_byte_tb_top.sv
// self-checking bench for the release number and first configuration byte
`timescale 1ns/1ps
module hub_release_and_config_byte_tb_top;
  logic clock = 1'b0;
  logic rst = 1'b1;
  logic eeprom_source, eeprom_wr_en, smbus_wr_en, smbus_rd_en, smbus_rd_valid;
  logic [7:0] smbus_addr, smbus_wr_data, smbus_rd_data, a, d;
  wire logic [7:0] eeprom_addr = smbus_addr;
  wire logic [7:0] eeprom_wr_data = smbus_wr_data;
  logic local_supply_present = 1'b0, host_single_tt = 1'b0, full_speed_mode = 1'b0;
  logic eof1_point = 1'b0, downstream_traffic_seen = 1'b0, ue, sel, sp;
  logic [6:0] bus_port_allowed = '0, port_available, port_high_current;
  logic [15:0] release_number;
  logic self_powered, high_speed_off, per_port_translator_active, dynamic_power_enable;
  logic eop_at_eof1;
  int miscompares = 0, checks_done = 0, cycles = 0;
  int mdl [9];
  cfg_source_model u_host (.*);
  hub_release_and_config_byte #(.PORTS(7)) u_dut (.*);
  initial forever #2 clock = ~clock;
  always @(posedge clock) begin
    cycles++;
    if (cycles == 5000) begin
      miscompares++;
      end_of_test();
    end
  end
  task automatic end_of_test();
    $display("checks %0d mismatches %0d", checks_done, miscompares);
    if (miscompares == 0 && checks_done > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask
  task automatic chk(input logic [15:0] got, input int expv);
    checks_done++;
    if (got !== expv[15:0]) begin
      miscompares++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, expv[15:0]);
    end
  endtask
  task automatic rd_chk(input logic [7:0] ra);
    u_host.access(1'b0, 1'b0, 1'b1, ra, 8'h00);
    chk(smbus_rd_valid, 1);
    // unmapped 08h reads zero, 06h hides bit 6, 07h keeps only bit 7
    chk(smbus_rd_data, ra == 6 ? mdl[6] & 8'hBF : ra == 7 ? mdl[7] & 8'h80 : mdl[ra]);
  endtask
  initial begin
    void'($urandom(43422));
    repeat (20) @(negedge clock);
    rst = 1'b0;
    for (int i = 4; i < 9; i++) rd_chk(i[7:0]);
    $display("reset readback test done");
    for (int i = 0; i < 60; i++) begin
      a = 8'h04 + 8'($urandom_range(4));
      d = 8'($urandom);
      ue = 1'($urandom);
      sel = 1'($urandom);
      local_supply_present = 1'($urandom);
      host_single_tt = 1'($urandom);
      bus_port_allowed = 7'($urandom);
      u_host.access(ue, sel, 1'b0, a, d);
      if (ue == sel && a < 8) mdl[a] = d;
      rd_chk(a);
      repeat (2) @(negedge clock);
      sp = mdl[7][7] ? local_supply_present : mdl[6][7];
      chk(self_powered, sp);
      chk(port_available, sp ? 7'h7F : bus_port_allowed);
      chk(port_high_current, sp ? 7'h7F : 7'h00);
      chk(high_speed_off, mdl[6][5]);
      chk(per_port_translator_active, mdl[6][4] & !host_single_tt);
      chk(dynamic_power_enable, mdl[7][7]);
      chk(release_number, {mdl[5][7:0], mdl[4][7:0]});
      eof1_point = 1'b1;
      full_speed_mode = 1'($urandom);
      downstream_traffic_seen = 1'($urandom);
      @(negedge clock);
      eof1_point = 1'b0;
      chk(eop_at_eof1, full_speed_mode & !downstream_traffic_seen & !mdl[6][3]);
    end
    $display("random configuration test done");
    end_of_test();
  end
endmodule
